// ==== ppm_pkg.sv ====
// constants, field layout and carrier types of the power management capability block
// Notes on behaviour
// - version field reads fixed revision code
// - wake clock bit reads constant zero
// - special initialization flag reads zero
// - aux current reads zero without cold wake
// - aux current codes map to milliamp levels
// - state1 and state2 support bits read one
// - cold wake bit defaults zero, unlock-writable
// - lower wake support bits read ones
// - protected capability fields written only unlocked
// - serial ROM load precedes configuration access
// - power state field reads and writes
// - data select and scale read zero
// - wake enable gates wake output
// - sticky wake bits survive reset with cold
// - port event sets wake status, write-one-clears
// - non-D0 state stops the internal clock
// - write unlock defaults zero, masks protected writes
package ppm_pkg;
  // register select
  localparam logic SEL_CAP = 1'h0;
  localparam logic SEL_CTRL = 1'h1;
  localparam int DATA_W = 16;
  // capability register layout
  localparam int VERSION_LSB = 0;
  localparam logic [2:0] VERSION_CODE = 3'h2;
  localparam int WAKE_CLOCK_BIT = 3;
  localparam int CAP_RSVD_BIT = 4;
  localparam int DSI_BIT = 5;
  localparam int AUX_LSB = 6;
  localparam int AUX_W = 3;
  localparam int STATE1_BIT = 9;
  localparam int STATE2_BIT = 10;
  localparam int WAKE_SUP_LSB = 11;
  localparam logic [3:0] WAKE_SUP_FIXED = 4'hF;
  localparam int D3COLD_BIT = 15;
  localparam logic [2:0] AUX_RESET = 3'h0;
  localparam logic D3COLD_RESET = 1'h0;
  // aux current codes, milliamps at 3.3 V aux
  localparam logic [2:0] AUX_375MA = 3'h7;
  localparam logic [2:0] AUX_320MA = 3'h6;
  localparam logic [2:0] AUX_270MA = 3'h5;
  localparam logic [2:0] AUX_220MA = 3'h4;
  localparam logic [2:0] AUX_160MA = 3'h3;
  localparam logic [2:0] AUX_100MA = 3'h2;
  localparam logic [2:0] AUX_55MA = 3'h1;
  localparam logic [2:0] AUX_SELF_POWERED = 3'h0;
  // control/status register layout
  localparam int PSTATE_LSB = 0;
  localparam int WAKE_EN_BIT = 8;
  localparam int WAKE_STAT_BIT = 15;
  localparam logic [1:0] PS_D0 = 2'h0;
  localparam logic [1:0] PS_D1 = 2'h1;
  localparam logic [1:0] PS_D2 = 2'h2;
  localparam logic [1:0] PS_D3 = 2'h3;
  localparam logic [1:0] PSTATE_RESET = 2'h0;

  typedef enum logic [1:0] {LOAD_STRAP, LOAD_WAIT, RUN} ppm_phase_t;

  typedef struct packed {
    logic write;
    logic sel;
    logic [1:0] byte_en;
    logic [15:0] wdata;
  } ppm_cfg_t;

  typedef struct packed {
    logic [2:0] aux_current;
    logic d3cold;
  } ppm_rom_t;
endpackage

// ==== ppm_capability.sv ====
// power management capability and control/status registers
`timescale 1ns/100ps
module ppm_capability (
  // clock and resets
  input wire logic clock,
  input wire logic rst_n,
  input wire logic por_n,
  // configuration access
  input wire logic cfg_req,
  input wire ppm_pkg::ppm_cfg_t cfg,
  output logic cfg_ready,
  output logic cfg_ack,
  output logic [15:0] cfg_rdata,
  // unlock from the extension register
  input wire logic id_write_unlock,
  // serial ROM preload
  input wire logic rom_present,
  input wire logic rom_word_valid,
  input wire ppm_pkg::ppm_rom_t rom_word,
  // wake path
  input wire logic port_wake_event,
  output logic wake_event_out_n,
  // core clock control
  output logic core_clock_en
);

  typedef struct packed {
    ppm_pkg::ppm_phase_t phase;
    logic [2:0] aux_current;
    logic d3cold;
    logic [1:0] power_state;
    logic ack;
    logic [15:0] rdata;
  } ppm_core_t;

  // wake bits live on the power-on reset so a warm reset keeps them when the preload advertises cold wake
  typedef struct packed {
    logic wake_enable;
    logic wake_status;
  } ppm_sticky_t;

  ppm_core_t core;
  ppm_core_t next_core;
  ppm_sticky_t sticky;
  ppm_sticky_t next_sticky;

  logic taken;
  logic cap_write;
  logic ctrl_write;
  logic load_finish;
  logic [15:0] cap_word;
  logic [15:0] ctrl_word;

  // no access is served until the preload phase is over
  assign cfg_ready = (core.phase == ppm_pkg::RUN);
  assign taken = cfg_req && cfg_ready;
  assign cap_write = taken && cfg.write && (cfg.sel == ppm_pkg::SEL_CAP);
  assign ctrl_write = taken && cfg.write && (cfg.sel == ppm_pkg::SEL_CTRL);

  assign cfg_ack = core.ack;
  assign cfg_rdata = core.rdata;

  // D1, D2 and D3 all count as global suspend
  assign core_clock_en = (core.power_state == ppm_pkg::PS_D0);

  // both inputs are flops, so the pin cannot glitch from logic hazards
  assign wake_event_out_n = !(sticky.wake_status && sticky.wake_enable);

  always_comb begin
    cap_word = 16'h0000;
    cap_word[ppm_pkg::VERSION_LSB +: 3] = ppm_pkg::VERSION_CODE;
    cap_word[ppm_pkg::WAKE_CLOCK_BIT] = 1'h0;
    cap_word[ppm_pkg::CAP_RSVD_BIT] = 1'h0;
    cap_word[ppm_pkg::DSI_BIT] = 1'h0;
    // aux code is only meaningful when cold wake is advertised
    if (core.d3cold) begin
      cap_word[ppm_pkg::AUX_LSB +: ppm_pkg::AUX_W] = core.aux_current;
    end else begin
      cap_word[ppm_pkg::AUX_LSB +: ppm_pkg::AUX_W] = ppm_pkg::AUX_SELF_POWERED;
    end
    cap_word[ppm_pkg::STATE1_BIT] = 1'h1;
    cap_word[ppm_pkg::STATE2_BIT] = 1'h1;
    cap_word[ppm_pkg::WAKE_SUP_LSB +: 4] = ppm_pkg::WAKE_SUP_FIXED;
    cap_word[ppm_pkg::D3COLD_BIT] = core.d3cold;
  end

  always_comb begin
    ctrl_word = 16'h0000;
    ctrl_word[ppm_pkg::PSTATE_LSB +: 2] = core.power_state;
    ctrl_word[ppm_pkg::WAKE_EN_BIT] = sticky.wake_enable;
    ctrl_word[ppm_pkg::WAKE_STAT_BIT] = sticky.wake_status;
  end

  always_comb begin
    next_core = core;
    next_core.ack = 1'h0;
    load_finish = 1'h0;
    case (core.phase)
      ppm_pkg::LOAD_STRAP: begin
        // strap is looked at only after reset has gone away
        if (rom_present) begin
          next_core.phase = ppm_pkg::LOAD_WAIT;
        end else begin
          next_core.phase = ppm_pkg::RUN;
          load_finish = 1'h1;
        end
      end
      ppm_pkg::LOAD_WAIT: begin
        // a ROM that never answers holds the block off for good
        if (rom_word_valid) begin
          next_core.aux_current = rom_word.aux_current;
          next_core.d3cold = rom_word.d3cold;
          next_core.phase = ppm_pkg::RUN;
          load_finish = 1'h1;
        end
      end
      ppm_pkg::RUN: begin
        if (taken) begin
          next_core.ack = 1'h1;
          if (!cfg.write) begin
            if (cfg.sel == ppm_pkg::SEL_CAP) begin
              next_core.rdata = cap_word;
            end else begin
              next_core.rdata = ctrl_word;
            end
          end
        end
        if (cap_write && id_write_unlock) begin
          if (cfg.byte_en[0]) begin
            next_core.aux_current[1:0] = cfg.wdata[ppm_pkg::AUX_LSB +: 2];
          end
          if (cfg.byte_en[1]) begin
            next_core.aux_current[2] = cfg.wdata[ppm_pkg::AUX_LSB + 2];
            next_core.d3cold = cfg.wdata[ppm_pkg::D3COLD_BIT];
          end
        end
        if (ctrl_write && cfg.byte_en[0]) begin
          next_core.power_state = cfg.wdata[ppm_pkg::PSTATE_LSB +: 2];
        end
      end
      default: begin
        next_core.phase = ppm_pkg::LOAD_STRAP;
      end
    endcase
  end

  always_comb begin
    next_sticky = sticky;
    // without cold wake the bits must not outlive a warm reset
    if (load_finish && !next_core.d3cold) begin
      next_sticky.wake_enable = 1'h0;
      next_sticky.wake_status = 1'h0;
    end
    if (ctrl_write && cfg.byte_en[1]) begin
      next_sticky.wake_enable = cfg.wdata[ppm_pkg::WAKE_EN_BIT];
      if (cfg.wdata[ppm_pkg::WAKE_STAT_BIT]) begin
        next_sticky.wake_status = 1'h0;
      end
    end
    // a port event in the clearing cycle is kept
    if (port_wake_event) begin
      next_sticky.wake_status = 1'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      core.phase <= ppm_pkg::LOAD_STRAP;
      core.aux_current <= ppm_pkg::AUX_RESET;
      core.d3cold <= ppm_pkg::D3COLD_RESET;
      core.power_state <= ppm_pkg::PSTATE_RESET;
      core.ack <= 1'h0;
      core.rdata <= 16'h0000;
    end else begin
      core <= next_core;
    end
  end

  always_ff @(posedge clock or negedge por_n) begin
    if (!por_n) begin
      sticky <= '0;
    end else begin
      sticky <= next_sticky;
    end
  end

  sequence s_cap_read;
    taken && !cfg.write && (cfg.sel == ppm_pkg::SEL_CAP);
  endsequence

  sequence s_ctrl_read;
    taken && !cfg.write && (cfg.sel == ppm_pkg::SEL_CTRL);
  endsequence

  sequence s_locked_cap_write;
    cap_write && !id_write_unlock;
  endsequence

  property p_cap_fixed;
    @(posedge clock) disable iff (!rst_n)
    s_cap_read |=> cfg_ack && (cfg_rdata[5:0] == 6'h02) && (cfg_rdata[14:9] == 6'h3F);
  endproperty
  a_cap_fixed: assert property (p_cap_fixed) else $error("capability constant bits wrong");

  property p_aux_zero;
    @(posedge clock) disable iff (!rst_n)
    s_cap_read ##1 !cfg_rdata[15] |-> (cfg_rdata[8:6] == 3'h0);
  endproperty
  a_aux_zero: assert property (p_aux_zero) else $error("aux current nonzero without cold wake");

  property p_locked;
    @(posedge clock) disable iff (!rst_n)
    s_locked_cap_write |=> $stable(core.aux_current) && $stable(core.d3cold);
  endproperty
  a_locked: assert property (p_locked) else $error("protected field written while locked");

  property p_unlocked;
    @(posedge clock) disable iff (!rst_n)
    cap_write && id_write_unlock && cfg.byte_en[1] |=> core.d3cold == $past(cfg.wdata[15]);
  endproperty
  a_unlocked: assert property (p_unlocked) else $error("unlocked write lost");

  property p_hold_off;
    @(posedge clock) disable iff (!rst_n)
    (core.phase != ppm_pkg::RUN) |-> !cfg_ready ##1 !cfg_ack;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("access served before preload");

  property p_state_write;
    @(posedge clock) disable iff (!rst_n)
    ctrl_write && cfg.byte_en[0] |=> (core.power_state == $past(cfg.wdata[1:0]))
      && (core_clock_en == ($past(cfg.wdata[1:0]) == ppm_pkg::PS_D0));
  endproperty
  a_state_write: assert property (p_state_write) else $error("power state write wrong");

  property p_ctrl_zero;
    @(posedge clock) disable iff (!rst_n)
    s_ctrl_read |=> (cfg_rdata[14:9] == 6'h00) && (cfg_rdata[7:2] == 6'h00);
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("data fields not zero");

  property p_status_set;
    @(posedge clock) disable iff (!por_n)
    port_wake_event |=> sticky.wake_status;
  endproperty
  a_status_set: assert property (p_status_set) else $error("wake status missed event");

  property p_status_clear;
    @(posedge clock) disable iff (!por_n)
    ctrl_write && cfg.byte_en[1] && cfg.wdata[15] && !port_wake_event |=> !sticky.wake_status;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("wake status not cleared");

  property p_wake_gate;
    @(posedge clock) disable iff (!por_n)
    port_wake_event && sticky.wake_enable && !ctrl_write && !load_finish |=> !wake_event_out_n;
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("wake output not asserted");

  property p_no_enable;
    @(posedge clock) disable iff (!por_n)
    !sticky.wake_enable |-> wake_event_out_n;
  endproperty
  a_no_enable: assert property (p_no_enable) else $error("wake output without enable");

  property p_sticky_drop;
    @(posedge clock) disable iff (!rst_n || !por_n)
    load_finish && !next_core.d3cold && !port_wake_event |=> !sticky.wake_enable && !sticky.wake_status;
  endproperty
  a_sticky_drop: assert property (p_sticky_drop) else $error("wake bits kept without cold wake");

  // preload paths: the strap skip and the ROM word both open the bus
  sequence s_strap_skip;
    (core.phase == ppm_pkg::LOAD_STRAP) && !rom_present;
  endsequence

  sequence s_rom_take;
    (core.phase == ppm_pkg::LOAD_WAIT) && rom_word_valid;
  endsequence

  sequence s_rom_idle;
    (core.phase == ppm_pkg::LOAD_WAIT) && !rom_word_valid;
  endsequence

  property p_strap_skip;
    @(posedge clock) disable iff (!rst_n)
    s_strap_skip |=> cfg_ready;
  endproperty
  a_strap_skip: assert property (p_strap_skip) else $error("bus not opened without ROM");

  property p_rom_take;
    @(posedge clock) disable iff (!rst_n)
    s_rom_take |=> cfg_ready && (core.d3cold == $past(rom_word.d3cold))
      && (core.aux_current == $past(rom_word.aux_current));
  endproperty
  a_rom_take: assert property (p_rom_take) else $error("ROM word not loaded");

  property p_rom_idle;
    @(posedge clock) disable iff (!rst_n)
    s_rom_idle |=> !cfg_ready;
  endproperty
  a_rom_idle: assert property (p_rom_idle) else $error("bus opened before ROM word");

  property p_preload_state;
    @(posedge clock) disable iff (!rst_n)
    (core.phase != ppm_pkg::RUN)
      |-> (core.power_state == ppm_pkg::PSTATE_RESET) && core_clock_en;
  endproperty
  a_preload_state: assert property (p_preload_state) else $error("state left D0 in preload");

  property p_ack_answer;
    @(posedge clock) disable iff (!rst_n)
    taken |=> cfg_ack;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("taken access not acknowledged");

  property p_ack_only;
    @(posedge clock) disable iff (!rst_n)
    !taken |=> !cfg_ack;
  endproperty
  a_ack_only: assert property (p_ack_only) else $error("acknowledge without access");

  property p_write_keeps_rdata;
    @(posedge clock) disable iff (!rst_n)
    taken && cfg.write |=> $stable(cfg_rdata);
  endproperty
  a_write_keeps_rdata: assert property (p_write_keeps_rdata) else $error("write moved read data");

  property p_cap_cold;
    @(posedge clock) disable iff (!rst_n)
    s_cap_read |=> (cfg_rdata[15] == $past(core.d3cold));
  endproperty
  a_cap_cold: assert property (p_cap_cold) else $error("cold wake bit misread");

  property p_aux_read;
    @(posedge clock) disable iff (!rst_n)
    s_cap_read ##1 cfg_rdata[15] |-> (cfg_rdata[8:6] == $past(core.aux_current));
  endproperty
  a_aux_read: assert property (p_aux_read) else $error("aux current misread");

  property p_ctrl_read;
    @(posedge clock) disable iff (!rst_n)
    s_ctrl_read |=> (cfg_rdata[1:0] == $past(core.power_state))
      && (cfg_rdata[8] == $past(sticky.wake_enable))
      && (cfg_rdata[15] == $past(sticky.wake_status));
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control word misread");

  property p_enable_write;
    @(posedge clock) disable iff (!por_n)
    ctrl_write && cfg.byte_en[1] |=> sticky.wake_enable == $past(cfg.wdata[8]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("wake enable write lost");

  property p_status_keep;
    @(posedge clock) disable iff (!por_n)
    ctrl_write && cfg.byte_en[1] && !cfg.wdata[15] && sticky.wake_status |=> sticky.wake_status;
  endproperty
  a_status_keep: assert property (p_status_keep) else $error("zero write cleared status");

endmodule

// ==== ppm_host_model.sv ====
// configuration host model issuing single register accesses
`timescale 1ns/100ps
module ppm_host_model (
  // bus clock
  input wire logic clock,
  // device answer
  input wire logic cfg_ready,
  input wire logic cfg_ack,
  input wire logic [15:0] cfg_rdata,
  // request
  output logic cfg_req,
  output ppm_pkg::ppm_cfg_t cfg
);
  initial begin
    cfg_req = 1'h0;
    cfg = '0;
  end

  // ready is looked at on the falling edge, so a phase change cannot race the taking edge
  task automatic access(input logic wr, input logic sel, input logic [1:0] be,
                        input logic [15:0] wd, output logic [15:0] rd, output logic ack);
    int n;
    n = 0;
    @(negedge clock);
    cfg_req = 1'h1;
    cfg = '{wr, sel, be, wd};
    while (cfg_ready !== 1'h1 && n++ < 200) @(negedge clock);
    @(negedge clock);
    ack = cfg_ack;
    rd = cfg_rdata;
    cfg_req = 1'h0;
    // released fields never keep the last word
    cfg = ~cfg;
  endtask
endmodule

// ==== pci_power_mgmt_capability_tb_top.sv ====
// self-checking bench of the power management capability registers
`timescale 1ns/100ps
module pci_power_mgmt_capability_tb_top;
  logic clock, rst_n, por_n, cfg_req, cfg_ready, cfg_ack, id_write_unlock;
  logic rom_present, rom_word_valid, port_wake_event, wake_event_out_n, core_clock_en;
  logic [15:0] cfg_rdata;
  ppm_pkg::ppm_cfg_t cfg;
  ppm_pkg::ppm_rom_t rom_word;
  int fail_count = 0;
  int num_checks = 0;
  int i;
  logic [31:0] seed;
  logic [31:0] r;

  ppm_capability u_dut (.clock(clock), .rst_n(rst_n), .por_n(por_n), .cfg_req(cfg_req),
    .cfg(cfg), .cfg_ready(cfg_ready), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .id_write_unlock(id_write_unlock), .rom_present(rom_present),
    .rom_word_valid(rom_word_valid), .rom_word(rom_word), .port_wake_event(port_wake_event),
    .wake_event_out_n(wake_event_out_n), .core_clock_en(core_clock_en));
  ppm_host_model u_host (.clock(clock), .cfg_ready(cfg_ready), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .cfg_req(cfg_req), .cfg(cfg));

  initial begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end

  function automatic logic [15:0] cap(input logic d3, input logic [2:0] a);
    return {d3, 4'hF, 2'h3, (d3 ? a : 3'h0), 3'h0, 3'h2};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic sel, input logic [15:0] exp);
    logic [15:0] v;
    logic a;
    u_host.access(1'h0, sel, 2'h3, 16'h0000, v, a);
    check({15'h0, a}, 16'h0001);
    check(v, exp);
  endtask

  task automatic wr(input logic sel, input logic [1:0] be, input logic [15:0] wd);
    logic [15:0] v;
    logic a;
    u_host.access(1'h1, sel, be, wd, v, a);
    check({15'h0, a}, 16'h0001);
  endtask

  task automatic reset(input logic por, input logic rom, input ppm_pkg::ppm_rom_t w);
    @(negedge clock);
    rst_n = 1'h0;
    por_n = ~por;
    rom_present = rom;
    repeat (3) @(negedge clock);
    rst_n = 1'h1;
    por_n = 1'h1;
    if (rom) begin
      repeat (3) @(negedge clock);
      check({15'h0, cfg_ready}, 16'h0000);
      rom_word = w;
      rom_word_valid = 1'h1;
      @(negedge clock);
      rom_word_valid = 1'h0;
      rom_word = ~w;
    end
    @(negedge clock);
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    summarize();
  end

  initial begin
    seed = 32'h0269;
    rst_n = 1'h0;
    por_n = 1'h0;
    id_write_unlock = 1'h0;
    rom_present = 1'h0;
    rom_word_valid = 1'h0;
    rom_word = '0;
    port_wake_event = 1'h0;
    reset(1'h1, 1'h0, '0);
    rd(1'h0, cap(1'h0, 3'h0));
    rd(1'h1, 16'h0000);
    // locked writes of random words leave the capability untouched
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      wr(1'h0, 2'h3, r[15:0]);
      rd(1'h0, cap(1'h0, 3'h0));
    end
    id_write_unlock = 1'h1;
    for (i = 0; i < 8; i++) begin
      wr(1'h0, 2'h3, {1'h1, 6'h00, i[2:0], 6'h00});
      rd(1'h0, cap(1'h1, i[2:0]));
    end
    wr(1'h0, 2'h3, 16'h0140);
    rd(1'h0, cap(1'h0, 3'h0));
    id_write_unlock = 1'h0;
    // byte0 only, so wake bits in byte1 stay put
    for (i = 3; i >= 0; i--) begin
      r = $random(seed);
      wr(1'h1, 2'h1, {r[15:2], i[1:0]});
      rd(1'h1, {14'h0, i[1:0]});
      check({15'h0, core_clock_en}, {15'h0, (i == 0)});
    end
    @(negedge clock);
    port_wake_event = 1'h1;
    @(negedge clock);
    port_wake_event = 1'h0;
    rd(1'h1, 16'h8000);
    check({15'h0, wake_event_out_n}, 16'h0001);
    wr(1'h1, 2'h2, 16'h0000);
    rd(1'h1, 16'h8000);
    wr(1'h1, 2'h2, 16'h0100);
    check({15'h0, wake_event_out_n}, 16'h0000);
    // warm reset with a cold-wake capable preload keeps the sticky bits
    reset(1'h0, 1'h1, '{3'h3, 1'h1});
    rd(1'h1, 16'h8100);
    rd(1'h0, cap(1'h1, 3'h3));
    wr(1'h1, 2'h2, 16'h8100);
    rd(1'h1, 16'h0100);
    check({15'h0, wake_event_out_n}, 16'h0001);
    // an event that lands on the clearing write wins over the clear
    port_wake_event = 1'h1;
    wr(1'h1, 2'h2, 16'h8100);
    port_wake_event = 1'h0;
    rd(1'h1, 16'h8100);
    check({15'h0, wake_event_out_n}, 16'h0000);
    reset(1'h0, 1'h1, '{3'h3, 1'h0});
    rd(1'h1, 16'h0000);
    rd(1'h0, cap(1'h0, 3'h0));
    summarize();
  end
endmodule
